// >>> hdl/jciu_core.sv
// Purpose: instruction decode and execution behind the test port
// Assumes: test pins are asynchronous to clk_sys_in
// Notes: column memory holds unknown data until bulk erased
// Notes on behaviour
// (RQ1) All-ones code selects one-bit bypass path
// (RQ2) Sample/preload puts boundary register on path
// (RQ3) All-zeros code enters external test, boundary path
// (RQ4) Identity code selects 32-bit identity register
// (RQ5) Identity readable after reset, no instruction
// (RQ6) Enable sets, disable clears programming flag
// (RQ7) Bulk erase clears all stored bits
// (RQ8) Address shift selects 10-bit address register
// (RQ9) Data shift selects 90-bit column register
// (RQ10) Column write stores column, programming only
// (RQ11) Write then increment address, programming only
// (RQ12) Lock fuse blocks readout, erase clears it
// (RQ13) Column readback loads column, programming only
// (RQ14) Readback then increment address, programming only
// (RQ15) Discharge drops programming voltage
// (RQ16) User tag write stores tag, programming only
// (RQ17) User tag read loads tag, selects it
// (RQ18) High-impedance instruction raises pins_highz_out to float the pins; the serial output still drives
// (RQ19) Clamp and idle drive pins from boundary
// (RQ20) User reset instruction resets user logic
// (RQ21) Valid erase clears valid bit, disables
// (RQ22) Valid write sets valid bit, enables
// (RQ23) Instruction register is eight bits
// (RQ24) Instruction capture loads identity code
// (RQ25) Sample on rising, drive on falling
// (RQ26) Mode select high five clocks resets
// (RQ27) Refused programming ops change nothing
//
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module jciu_core #(
  parameter int BSR_W = 16,
  parameter logic [31:0] ID_VALUE = 32'h1A5C_3001 // Arbitrary value
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic tck_in,
  input wire logic tms_in,
  input wire logic tdi_in,
  output logic tdo_out,
  output logic tdo_oe_out,
  input wire logic [7:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic [BSR_W-1:0] bsr_pins_out,
  output logic pins_highz_out,
  output logic pins_from_bsr_out,
  output logic extest_mode_out,
  output logic user_reset_out,
  output logic dev_enable_out
);
  import jciu_pkg::*;

  // ************************************************
  // Pin synchronisers
  // ************************************************
  logic tck_s1, tck_s2, tck_s3;
  logic tms_s1, tms_s2, tdi_s1, tdi_s2;
  logic tck_rise, tck_fall;
  jciu_tap_e tap_st;

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      {tck_s1, tck_s2, tck_s3} <= 3'h0;
      {tms_s1, tms_s2, tdi_s1, tdi_s2} <= 4'hF;
    end else begin
      tck_s1 <= tck_in;
      tck_s2 <= tck_s1;
      tck_s3 <= tck_s2;
      tms_s1 <= tms_in;
      tms_s2 <= tms_s1;
      tdi_s1 <= tdi_in;
      tdi_s2 <= tdi_s1;
    end
  end

  // Edges seen from the second and third stages
  assign tck_rise = tck_s2 & ~tck_s3; // RQ25
  assign tck_fall = ~tck_s2 & tck_s3; // RQ25

  jciu_tap u_tap (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .step_in(tck_rise),
    .tms_in(tms_s2),
    .state_out(tap_st)
  );

  // ************************************************
  // Decoding
  // ************************************************
  function automatic jciu_path_e path_of(input logic [IR_W-1:0] ir);
    jciu_path_e p;
    p = PATH_BYP;
    if (ir[INS_BYPASS_BIT]) p = PATH_BYP; // RQ1
    else if (ir == INS_SAMPLE) p = PATH_BSR; // RQ2
    else if (ir == INS_EXTEST || ir == INS_INTEST) p = PATH_BSR; // RQ3
    else if (ir == INS_IDCODE) p = PATH_ID; // RQ4
    else if (ir == INS_ADDR_SHIFT) p = PATH_ADDR; // RQ8
    else if (ir == INS_DATA_SHIFT) p = PATH_COL; // RQ9
    else if (ir == INS_USER_TAG_READ) p = PATH_TAG; // RQ17
    return p;
  endfunction : path_of

  function automatic logic is_prog_op(input logic [IR_W-1:0] ir);
    return ir inside {INS_BULK_ERASE, INS_COLUMN_WRITE, INS_LOCK_WRITE,
      INS_COLUMN_READBACK, INS_USER_TAG_WRITE, INS_VALID_ERASE,
      INS_COLUMN_WRITE_NEXT, INS_COLUMN_READBACK_NEXT, INS_VALID_WRITE};
  endfunction : is_prog_op

  // ************************************************
  // Instruction register
  // ************************************************
  logic [IR_W-1:0] ir_sh_q, ir_q; // RQ23
  logic upd_ir, upd_dr, cap_dr, sh_dr, sh_ir;
  jciu_path_e path;

  assign upd_ir = tck_rise && tap_st == TS_UPD_IR;
  assign upd_dr = tck_rise && tap_st == TS_UPD_DR;
  assign cap_dr = tck_rise && tap_st == TS_CAP_DR;
  assign sh_dr = tck_rise && tap_st == TS_SH_DR;
  assign sh_ir = tck_rise && tap_st == TS_SH_IR;
  assign path = path_of(ir_q);

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      ir_sh_q <= INS_IDCODE;
    end else if (tck_rise && tap_st == TS_CAP_IR) begin
      ir_sh_q <= INS_IDCODE; // RQ24
    end else if (sh_ir) begin
      ir_sh_q <= {tdi_s2, ir_sh_q[IR_W-1:1]};
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      ir_q <= INS_IDCODE; // RQ5
    end else if (tck_rise && tap_st == TS_RESET) begin
      ir_q <= INS_IDCODE; // RQ5
    end else if (upd_ir) begin
      ir_q <= ir_sh_q;
    end
  end

  // ************************************************
  // Execution
  // ************************************************
  // Memory work waits for the next idle state, as the part runs it
  logic run_pend_q, prog_q, lock_q, valid_q, vpp_q, run_go, ops_ok;
  logic [IR_W-1:0] op;

  assign run_go = tck_rise && tap_st == TS_IDLE && run_pend_q;
  assign ops_ok = run_go && prog_q; // RQ27
  assign op = ir_q;

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      run_pend_q <= 1'b0;
    end else if (upd_ir) begin
      run_pend_q <= is_prog_op(ir_sh_q);
    end else if (run_go) begin
      run_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      prog_q <= 1'b0;
    end else if (upd_ir && ir_sh_q == INS_PROG_ENABLE) begin
      prog_q <= 1'b1; // RQ6
    end else if (upd_ir && ir_sh_q == INS_PROG_DISABLE) begin
      prog_q <= 1'b0; // RQ6
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      lock_q <= 1'b0;
    end else if (ops_ok && op == INS_BULK_ERASE) begin
      lock_q <= 1'b0; // RQ7 RQ12
    end else if (ops_ok && op == INS_LOCK_WRITE) begin
      lock_q <= 1'b1; // RQ12
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      valid_q <= 1'b0;
    end else if (ops_ok && (op == INS_BULK_ERASE || op == INS_VALID_ERASE)) begin
      valid_q <= 1'b0; // RQ7 RQ21
    end else if (ops_ok && op == INS_VALID_WRITE) begin
      valid_q <= 1'b1; // RQ22
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      vpp_q <= 1'b0;
    end else if (upd_ir && ir_sh_q == INS_DISCHARGE) begin
      vpp_q <= 1'b0; // RQ15
    end else if (ops_ok && !(op inside {INS_COLUMN_READBACK,
                                        INS_COLUMN_READBACK_NEXT})) begin
      vpp_q <= 1'b1;
    end
  end

  // ************************************************
  // Data registers
  // ************************************************
  logic byp_q;
  logic [BSR_W-1:0] bsr_q, bsr_hold_q;
  logic [ID_W-1:0] id_q;
  logic [ADDR_W-1:0] addr_q;
  logic [COL_W-1:0] col_q;
  logic [TAG_W-1:0] tag_q, tag_nv_q;
  logic [COL_W-1:0] col_mem [0:(1<<ADDR_W)-1];
  logic [31:0] pins_q;

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      byp_q <= 1'b0;
    end else if (cap_dr) begin
      byp_q <= 1'b0;
    end else if (sh_dr && path == PATH_BYP) begin
      byp_q <= tdi_s2; // RQ1
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      bsr_q <= '0;
    end else if (cap_dr && path == PATH_BSR) begin
      bsr_q <= pins_q[BSR_W-1:0]; // RQ2
    end else if (sh_dr && path == PATH_BSR) begin
      bsr_q <= {tdi_s2, bsr_q[BSR_W-1:1]}; // RQ3
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      bsr_hold_q <= '0;
    end else if (upd_dr && path == PATH_BSR) begin
      bsr_hold_q <= bsr_q;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      id_q <= ID_VALUE;
    end else if (cap_dr && path == PATH_ID) begin
      id_q <= ID_VALUE; // RQ4
    end else if (sh_dr && path == PATH_ID) begin
      id_q <= {tdi_s2, id_q[ID_W-1:1]};
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      addr_q <= '0;
    end else if (sh_dr && path == PATH_ADDR) begin
      addr_q <= {tdi_s2, addr_q[ADDR_W-1:1]}; // RQ8
    end else if (ops_ok && (op == INS_COLUMN_WRITE_NEXT ||
                            op == INS_COLUMN_READBACK_NEXT)) begin
      addr_q <= addr_q + 1'b1; // RQ11 RQ14
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      col_q <= '0;
    end else if (sh_dr && path == PATH_COL) begin
      col_q <= {tdi_s2, col_q[COL_W-1:1]}; // RQ9
    end else if (ops_ok && !lock_q && (op == INS_COLUMN_READBACK ||
                                       op == INS_COLUMN_READBACK_NEXT)) begin
      col_q <= col_mem[addr_q]; // RQ13 RQ14 RQ12
    end
  end

  // Erase clears the whole array in one cycle; costly but simple
  always_ff @(posedge clk_sys_in) begin
    if (ops_ok && op == INS_BULK_ERASE) begin
      for (int i = 0; i < (1 << ADDR_W); i++) begin
        col_mem[i] <= '0; // RQ7
      end
    end else if (ops_ok && (op == INS_COLUMN_WRITE ||
                            op == INS_COLUMN_WRITE_NEXT)) begin
      col_mem[addr_q] <= col_q; // RQ10 RQ11
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      tag_q <= '0;
    end else if (upd_ir && ir_sh_q == INS_USER_TAG_READ) begin
      tag_q <= tag_nv_q; // RQ17
    end else if (sh_dr && path == PATH_TAG) begin
      tag_q <= {tdi_s2, tag_q[TAG_W-1:1]};
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      tag_nv_q <= '0;
    end else if (ops_ok && op == INS_BULK_ERASE) begin
      tag_nv_q <= '0; // RQ7
    end else if (ops_ok && op == INS_USER_TAG_WRITE) begin
      tag_nv_q <= tag_q; // RQ16
    end
  end

  // ************************************************
  // Serial output
  // ************************************************
  logic tdo_bit, tdo_q, tdo_oe_q;

  always_comb begin
    tdo_bit = 1'b0;
    if (tap_st == TS_SH_IR) begin
      tdo_bit = ir_sh_q[0];
    end else begin
      unique case (path)
        PATH_BYP: tdo_bit = byp_q;
        PATH_BSR: tdo_bit = bsr_q[0];
        PATH_ID: tdo_bit = id_q[0];
        PATH_ADDR: tdo_bit = addr_q[0];
        PATH_COL: tdo_bit = col_q[0];
        PATH_TAG: tdo_bit = tag_q[0];
        default: tdo_bit = 1'b0;
      endcase
      if (lock_q && !(path inside {PATH_BYP, PATH_ID, PATH_TAG})) begin
        tdo_bit = 1'b0; // RQ12
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      tdo_q <= 1'b0;
      tdo_oe_q <= 1'b0;
    end else if (tck_fall) begin
      tdo_q <= tdo_bit; // RQ25
      tdo_oe_q <= tap_st == TS_SH_IR || tap_st == TS_SH_DR;
    end
  end

  assign tdo_out = tdo_q;
  assign tdo_oe_out = tdo_oe_q;

  // ************************************************
  // Pin modes
  // ************************************************
  logic highz_q, from_bsr_q, extest_q, ureset_q;

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      highz_q <= 1'b0;
      from_bsr_q <= 1'b0;
      extest_q <= 1'b0;
    end else begin
      highz_q <= ir_q == INS_HIGHZ; // RQ18
      from_bsr_q <= ir_q inside {INS_CLAMP, INS_IDLE_INSTRUCTION, INS_EXTEST}; // RQ19
      extest_q <= ir_q == INS_EXTEST; // RQ3
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      ureset_q <= 1'b0;
    end else begin
      ureset_q <= upd_ir && ir_sh_q == INS_USER_RESET; // RQ20
    end
  end

  assign bsr_pins_out = bsr_hold_q;
  assign pins_highz_out = highz_q;
  assign pins_from_bsr_out = from_bsr_q;
  assign extest_mode_out = extest_q;
  assign user_reset_out = ureset_q;
  assign dev_enable_out = valid_q; // RQ21 RQ22

  // ************************************************
  // APB slave
  // ************************************************
  logic [31:0] rd_d, prdata_q;
  logic err_d, err_q;

  always_comb begin
    rd_d = 32'h0000_0000;
    err_d = 1'b0;
    unique case (paddr_in)
      REG_STATUS: begin
        rd_d[ST_PROG] = prog_q;
        rd_d[ST_LOCK] = lock_q;
        rd_d[ST_VALID] = valid_q;
        rd_d[ST_VPP] = vpp_q;
        rd_d[ST_PEND] = run_pend_q;
        rd_d[ST_IR_LSB +: IR_W] = ir_q;
      end
      REG_PINS: rd_d = pins_q;
      REG_USER_TAG: rd_d = tag_nv_q;
      default: err_d = 1'b1;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      prdata_q <= 32'h0000_0000;
      err_q <= 1'b0;
    end else if (psel_in && !penable_in) begin
      prdata_q <= rd_d;
      err_q <= err_d;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      pins_q <= 32'h0000_0000;
    end else if (psel_in && penable_in && pwrite_in && paddr_in == REG_PINS) begin
      pins_q <= pwdata_in;
    end
  end

  assign prdata_out = prdata_q;
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in && penable_in && err_q;

  // ************************************************
  // Assertions
  // ************************************************
  logic [2:0] tms_cnt_q;

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      tms_cnt_q <= 3'h0;
    end else if (tck_rise) begin
      tms_cnt_q <= !tms_s2 ? 3'h0 :
        (tms_cnt_q == TMS_RESET_CLOCKS) ? tms_cnt_q : tms_cnt_q + 3'h1;
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  sequence s_upd_ir(logic [7:0] code);
    upd_ir && ir_sh_q == code;
  endsequence
  sequence s_run(logic [7:0] code);
    run_go && prog_q && ir_q == code;
  endsequence

  tms_reset_a: assert property (tms_cnt_q == TMS_RESET_CLOCKS |-> tap_st == TS_RESET) // RQ26
    else $error("five high mode clocks did not reach reset");
  reset_ident_a: assert property (tck_rise && tap_st == TS_RESET |=> ir_q == INS_IDCODE) // RQ5
    else $error("reset state lost identity instruction");
  ir_capture_a: assert property (tck_rise && tap_st == TS_CAP_IR |=> ir_sh_q == INS_IDCODE) // RQ24
    else $error("instruction capture not identity");
  prog_flag_a: assert property (s_upd_ir(INS_PROG_ENABLE) |=> prog_q [*2]) // RQ6
    else $error("programming flag not set");
  refuse_op_a: assert property (run_go && !prog_q |=> $stable(addr_q) && $stable(lock_q)
    && $stable(tag_nv_q) && $stable(valid_q)) // RQ27
    else $error("refused operation changed state");
  incr_a: assert property (s_run(INS_COLUMN_WRITE_NEXT) |=>
    addr_q == $past(addr_q) + 1'b1 && col_mem[$past(addr_q)] == $past(col_q)) // RQ11
    else $error("write and increment wrong");
  erase_a: assert property (s_run(INS_BULK_ERASE) |=> !lock_q && !valid_q && tag_nv_q == '0) // RQ7
    else $error("bulk erase left bits set");
  lock_out_a: assert property (tck_fall && lock_q && tap_st == TS_SH_DR
    && path == PATH_COL |=> !tdo_out) // RQ12
    else $error("locked column leaked on serial output");
  tdo_fall_a: assert property (tck_fall |=> tdo_out == $past(tdo_bit)) // RQ25
    else $error("serial output not updated on falling edge");
  highz_a: assert property (ir_q == INS_HIGHZ |=> pins_highz_out) // RQ18
    else $error("high impedance not applied");
  valid_a: assert property (s_run(INS_VALID_WRITE) |=> dev_enable_out ##1 dev_enable_out) // RQ22
    else $error("valid write did not enable device");
  discharge_a: assert property (s_upd_ir(INS_DISCHARGE) |=> !vpp_q) // RQ15
    else $error("discharge left voltage on");
endmodule : jciu_core

// >>> hdl/jciu_pkg.sv
// Purpose: shared constants and types for the test port instruction unit
// Assumes: one system clock samples every test pin
// Notes: instruction codes are eight bits wide
package jciu_pkg;
  // ************************************************
  // Widths
  // ************************************************
  localparam int IR_W = 8;
  localparam int ADDR_W = 10;
  localparam int COL_W = 90;
  localparam int ID_W = 32;
  localparam int TAG_W = 32;
  localparam logic [2:0] TMS_RESET_CLOCKS = 3'h5;
  // ************************************************
  // Instruction codes
  // ************************************************
  localparam logic [7:0] INS_EXTEST = 8'h00;
  localparam logic [7:0] INS_ADDR_SHIFT = 8'h01;
  localparam logic [7:0] INS_DATA_SHIFT = 8'h02;
  localparam logic [7:0] INS_BULK_ERASE = 8'h03;
  localparam logic [7:0] INS_COLUMN_WRITE = 8'h07;
  localparam logic [7:0] INS_LOCK_WRITE = 8'h09;
  localparam logic [7:0] INS_COLUMN_READBACK = 8'h0A;
  localparam logic [7:0] INS_DISCHARGE = 8'h14;
  localparam logic [7:0] INS_PROG_ENABLE = 8'h15;
  localparam logic [7:0] INS_IDCODE = 8'h16;
  localparam logic [7:0] INS_USER_TAG_READ = 8'h17;
  localparam logic [7:0] INS_USER_TAG_WRITE = 8'h1A;
  localparam logic [7:0] INS_PROG_DISABLE = 8'h1E;
  localparam logic [7:0] INS_HIGHZ = 8'h18;
  localparam logic [7:0] INS_SAMPLE = 8'h1C;
  localparam logic [7:0] INS_CLAMP = 8'h20;
  localparam logic [7:0] INS_USER_RESET = 8'h22;
  localparam logic [7:0] INS_INTEST = 8'h2C;
  localparam logic [7:0] INS_VALID_ERASE = 8'h24;
  localparam logic [7:0] INS_COLUMN_WRITE_NEXT = 8'h27;
  localparam logic [7:0] INS_COLUMN_READBACK_NEXT = 8'h2A;
  localparam logic [7:0] INS_VALID_WRITE = 8'h2F;
  localparam logic [7:0] INS_IDLE_INSTRUCTION = 8'h30;
  localparam int INS_BYPASS_BIT = 7;
  // ************************************************
  // Register map
  // ************************************************
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_PINS = 8'h04;
  localparam logic [7:0] REG_USER_TAG = 8'h08;
  localparam int ST_PROG = 0;
  localparam int ST_LOCK = 1;
  localparam int ST_VALID = 2;
  localparam int ST_VPP = 3;
  localparam int ST_PEND = 4;
  localparam int ST_IR_LSB = 8;
  // ************************************************
  // Types
  // ************************************************
  typedef enum logic [15:0] {
    TS_RESET = 16'h0001, TS_IDLE = 16'h0002, TS_SEL_DR = 16'h0004,
    TS_CAP_DR = 16'h0008, TS_SH_DR = 16'h0010, TS_EX1_DR = 16'h0020,
    TS_PAU_DR = 16'h0040, TS_EX2_DR = 16'h0080, TS_UPD_DR = 16'h0100,
    TS_SEL_IR = 16'h0200, TS_CAP_IR = 16'h0400, TS_SH_IR = 16'h0800,
    TS_EX1_IR = 16'h1000, TS_PAU_IR = 16'h2000, TS_EX2_IR = 16'h4000,
    TS_UPD_IR = 16'h8000
  } jciu_tap_e;
  typedef enum logic [2:0] {
    PATH_BYP = 3'h0, PATH_BSR = 3'h1, PATH_ID = 3'h2,
    PATH_ADDR = 3'h3, PATH_COL = 3'h4, PATH_TAG = 3'h5
  } jciu_path_e;
endpackage : jciu_pkg

// >>> hdl/jciu_tap.sv
// Purpose: sixteen-state test port sequencer
// Assumes: step_in pulses once per rising test clock
// Notes: mode select is already synchronised
`timescale 1ns/1ps
module jciu_tap (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic step_in,
  input wire logic tms_in,
  output jciu_pkg::jciu_tap_e state_out
);
  import jciu_pkg::*;
  jciu_tap_e st_q;
  jciu_tap_e st_d;

  // ************************************************
  // Next state
  // ************************************************
  always_comb begin
    unique case (st_q)
      TS_RESET: st_d = tms_in ? TS_RESET : TS_IDLE;
      TS_IDLE: st_d = tms_in ? TS_SEL_DR : TS_IDLE;
      TS_SEL_DR: st_d = tms_in ? TS_SEL_IR : TS_CAP_DR;
      TS_CAP_DR: st_d = tms_in ? TS_EX1_DR : TS_SH_DR;
      TS_SH_DR: st_d = tms_in ? TS_EX1_DR : TS_SH_DR;
      TS_EX1_DR: st_d = tms_in ? TS_UPD_DR : TS_PAU_DR;
      TS_PAU_DR: st_d = tms_in ? TS_EX2_DR : TS_PAU_DR;
      TS_EX2_DR: st_d = tms_in ? TS_UPD_DR : TS_SH_DR;
      TS_UPD_DR: st_d = tms_in ? TS_SEL_DR : TS_IDLE;
      TS_SEL_IR: st_d = tms_in ? TS_RESET : TS_CAP_IR; // RQ26
      TS_CAP_IR: st_d = tms_in ? TS_EX1_IR : TS_SH_IR;
      TS_SH_IR: st_d = tms_in ? TS_EX1_IR : TS_SH_IR;
      TS_EX1_IR: st_d = tms_in ? TS_UPD_IR : TS_PAU_IR;
      TS_PAU_IR: st_d = tms_in ? TS_EX2_IR : TS_PAU_IR;
      TS_EX2_IR: st_d = tms_in ? TS_UPD_IR : TS_SH_IR;
      TS_UPD_IR: st_d = tms_in ? TS_SEL_DR : TS_IDLE;
      // Corrupt one-hot code falls back to reset
      default: st_d = TS_RESET;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      st_q <= TS_RESET;
    end else if (step_in) begin
      st_q <= st_d; // RQ25
    end
  end

  assign state_out = st_q;
endmodule : jciu_tap

// >>> sim/jciu_tester.sv
// Purpose: test port driver standing in for an external tester
// Assumes: eight system clocks per test clock half period
// Notes: clock stands low between frames, data line idles high
`timescale 1ns/1ps
module jciu_tester (
  input wire logic clk_sys_in,
  input wire logic tdo_in,
  output logic tck_out,
  output logic tms_out,
  output logic tdi_out
);
  initial begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b1;
  end
  task automatic step(input logic m, input logic d, output logic q);
    @(posedge clk_sys_in);
    tms_out <= m;
    tdi_out <= d;
    repeat (7) @(posedge clk_sys_in);
    q = tdo_in;
    tck_out <= 1'b1;
    repeat (8) @(posedge clk_sys_in);
    tck_out <= 1'b0;
  endtask : step
  task automatic scan(input logic ir, input int n, input logic [89:0] din,
      output logic [89:0] dout);
    logic q;
    dout = '0;
    step(1'b1, 1'b1, q);
    if (ir) step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
    step(1'b0, 1'b1, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
  endtask : scan
  // Mode select held high is the only way back to reset
  task automatic park(input int n, input logic m);
    logic q;
    repeat (n) step(m, 1'b1, q);
  endtask : park
endmodule : jciu_tester

// >>> sim/tb_jciu_core.sv
// Purpose: self-checking bench for the test port instruction unit
// Assumes: tester model drives the test pins, bench drives APB
// Notes: column memory is bulk erased before any readback
`timescale 1ns/1ps
module tb_jciu_core;
  import jciu_pkg::*;
  localparam logic [31:0] ID_V = 32'h5A3C_00F1; // Arbitrary value
  localparam logic [7:0] MC [5] = '{INS_HIGHZ, INS_CLAMP, INS_IDLE_INSTRUCTION, INS_EXTEST,
    INS_INTEST};
  localparam logic [2:0] ME [5] = '{3'h4, 3'h2, 3'h2, 3'h3, 3'h0};
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic tck, tms, tdi, tdo, oe, pready, pslverr, hz, fb, ext, urst, en, er;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic urs = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, seed, s;
  logic [15:0] pins;
  int num_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  always #5 clk_sys_in = ~clk_sys_in;
  jciu_core #(.BSR_W(16), .ID_VALUE(ID_V)) i_jciu_core (.clk_sys_in(clk_sys_in),
    .rst_in(rst_in), .tck_in(tck), .tms_in(tms), .tdi_in(tdi), .tdo_out(tdo),
    .tdo_oe_out(oe), .paddr_in(paddr), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .bsr_pins_out(pins), .pins_highz_out(hz),
    .pins_from_bsr_out(fb), .extest_mode_out(ext), .user_reset_out(urst),
    .dev_enable_out(en));
  jciu_tester i_jciu_tester (.clk_sys_in(clk_sys_in), .tdo_in(tdo), .tck_out(tck),
    .tms_out(tms), .tdi_out(tdi));
  always @(posedge clk_sys_in) begin
    if (urst === 1'b1) urs <= 1'b1;
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test
  task automatic chk(input string nm, input logic [89:0] seen, input logic [89:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd
  // Bypass cell captures zero, so data comes out one bit late
  function automatic logic [7:0] byp(input logic [7:0] x);
    return {x[6:0], 1'b0};
  endfunction : byp
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
    @(posedge clk_sys_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys_in);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys_in);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic st();
    apb(1'b0, REG_STATUS, 32'h0, s);
  endtask : st
  task automatic dr(input int n, input logic [89:0] d, output logic [89:0] r);
    i_jciu_tester.scan(1'b0, n, d, r);
  endtask : dr
  // One idle clock after the load lets memory operations run
  task automatic ir(input logic [7:0] c);
    logic [89:0] r;
    i_jciu_tester.scan(1'b1, 8, {82'h0, c}, r);
    i_jciu_tester.park(1, 1'b0);
  endtask : ir
  initial begin
    logic [89:0] d, d2, r;
    logic [95:0] w;
    logic [31:0] v, t;
    logic [7:0] c;
    seed = 32'h7BCEF2FA;
    repeat (20) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    i_jciu_tester.park(1, 1'b0);
    dr(32, 90'h0, r);
    chk("idcode", r, ID_V);
    v = rnd();
    c = {1'b1, v[6:0]};
    i_jciu_tester.scan(1'b1, 8, {82'h0, c}, r);
    chk("ir capture", r, INS_IDCODE);
    i_jciu_tester.park(1, 1'b0);
    dr(8, {58'h0, v}, r);
    chk("bypass", r, byp(v[7:0]));
    st();
    chk("ir held", s[15:8], c);
    $display("identity and bypass done");
    ir(INS_LOCK_WRITE);
    ir(INS_VALID_WRITE);
    st();
    chk("refused", s[2:0], 3'h0);
    ir(INS_PROG_ENABLE);
    st();
    chk("prog on", s[0], 1'b1);
    chk("oe idle", oe, 1'b0);
    ir(INS_BULK_ERASE);
    w = {rnd(), rnd(), rnd()};
    d = w[89:0];
    w = {rnd(), rnd(), rnd()};
    d2 = w[89:0];
    t = rnd();
    for (int k = 0; k < 2; k++) begin
      ir(INS_ADDR_SHIFT);
      dr(10, {80'h0, t[9:0]}, r);
      ir(INS_DATA_SHIFT);
      dr(90, k ? 90'h0 : d, r);
      ir(k ? INS_COLUMN_READBACK_NEXT : INS_COLUMN_WRITE_NEXT);
      ir(INS_DATA_SHIFT);
      dr(90, k ? 90'h0 : d2, r);
      if (k) chk("col first", r, d);
      ir(k ? INS_COLUMN_READBACK : INS_COLUMN_WRITE);
    end
    ir(INS_DATA_SHIFT);
    dr(90, d, r);
    chk("col next", r, d2);
    ir(INS_DISCHARGE);
    st();
    chk("vpp off", s[3], 1'b0);
    ir(INS_VALID_WRITE);
    chk("enable", en, 1'b1);
    ir(INS_VALID_ERASE);
    chk("disable", en, 1'b0);
    $display("memory done");
    ir(INS_USER_TAG_READ);
    dr(32, {58'h0, t}, r);
    ir(INS_USER_TAG_WRITE);
    apb(1'b0, REG_USER_TAG, 32'h0, v);
    chk("tag stored", v, t);
    ir(INS_USER_TAG_READ);
    dr(32, 90'h0, r);
    chk("tag read", r, t);
    apb(1'b1, REG_PINS, t, v);
    apb(1'b0, REG_PINS, 32'h0, v);
    chk("pins reg", v[15:0], t[15:0]);
    ir(INS_SAMPLE);
    dr(16, {74'h0, ~t[15:0]}, r);
    chk("boundary", r, t[15:0]);
    chk("preload", pins, {74'h0, ~t[15:0]});
    foreach (MC[i]) begin
      ir(MC[i]);
      chk("pin mode", {hz, fb, ext}, ME[i]);
    end
    ir(INS_USER_RESET);
    chk("user reset", urs, 1'b1);
    ir(INS_LOCK_WRITE);
    st();
    chk("fuse", s[1], 1'b1);
    ir(INS_COLUMN_READBACK);
    ir(INS_DATA_SHIFT);
    dr(90, 90'h0, r);
    chk("locked col", r, 90'h0);
    ir(INS_BULK_ERASE);
    st();
    chk("fuse clear", s[1], 1'b0);
    ir(INS_PROG_DISABLE);
    st();
    chk("prog off", s[0], 1'b0);
    apb(1'b0, 8'h0C, 32'h0, v);
    chk("unmapped", {er, v}, {1'b1, 32'h0});
    i_jciu_tester.park(5, 1'b1);
    i_jciu_tester.park(1, 1'b0);
    dr(32, 90'h0, r);
    chk("reset id", r, ID_V);
    $display("modes and reset done");
    end_of_test();
  end
endmodule : tb_jciu_core
